// [bench/xic_cpu_side.sv]
// Model of the CPU side: decides where execution goes after a wake.
// Assumes the controller's request outputs share the detection clock.
`timescale 1ns/1ps
`default_nettype none
module xic_cpu_side #(
    parameter int N = xic_pkg::NUM_LINES
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [N-1:1] irq_req,
    input  wire logic         nmi_req,
    input  wire logic         wake_request,
    output var  logic         woke,
    output var  logic         to_handler
);
    logic w1;
    logic w2;

    // Decide two edges after wake rises, so a late request still counts
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            w1 <= 1'h0;
            w2 <= 1'h0;
            woke <= 1'h0;
            to_handler <= 1'h0;
        end else begin
            w1 <= wake_request;
            w2 <= w1;
            if (w1 && !w2) begin
                woke <= 1'h1;
                to_handler <= (|irq_req) | nmi_req;
            end else if (!w1) begin
                woke <= 1'h0;
            end
        end
    end
endmodule // xic_cpu_side
`default_nettype wire

// [bench/xic_ext_irq_ctrl_bench.sv]
// Self-checking bench for the external interrupt controller.
// Assumes the design files and xic_pkg are compiled first.
`timescale 1ns/1ps
`default_nettype none
module xic_ext_irq_ctrl_bench;
    localparam int N = xic_pkg::NUM_LINES;
    logic         clk;
    logic         rst_n;
    logic [N-1:0] pin;
    logic [N-1:0] wr_data;
    logic [9:0]   stb;
    logic [N-1:0] mask_q;
    logic [N-1:0] pend_q;
    logic [N-1:0] en_q;
    logic [N-1:0] cfg_q [5];
    logic [N-1:1] irq_req;
    logic         nmi_req;
    logic         wake_request;
    logic         woke;
    logic         to_handler;
    int           miscompares = 0;
    int           n_checks = 0;
    int           cyc = 0;

    xic_ext_irq_ctrl dut (.clk(clk), .rst_n(rst_n), .ext_irq_pin(pin), .wr_data(wr_data),
        .mask_set_stb(stb[0]), .mask_clr_stb(stb[1]), .pend_clr_stb(stb[2]),
        .line_en_stb(stb[3]), .line_dis_stb(stb[4]), .mode_wr_stb(stb[5]),
        .edge_wr_stb(stb[6]), .level_wr_stb(stb[7]), .filter_wr_stb(stb[8]),
        .async_wr_stb(stb[9]), .mask_state(mask_q), .pending_state(pend_q),
        .line_enabled(en_q), .mode_state(cfg_q[0]), .edge_state(cfg_q[1]),
        .level_state(cfg_q[2]), .filter_state(cfg_q[3]), .async_state(cfg_q[4]),
        .irq_req(irq_req), .nmi_req(nmi_req), .wake_request(wake_request));

    xic_cpu_side cpu (.clk(clk), .rst_n(rst_n), .irq_req(irq_req), .nmi_req(nmi_req),
        .wake_request(wake_request), .woke(woke), .to_handler(to_handler));

    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    task automatic check(input logic [95:0] got, input logic [95:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Every task ends 1 ns after a rising edge, and all but the first go(10) at time 0 start there
    // Idle wait drops the strobes; a write leaves its strobe up
    task automatic go(input int n);
        stb = 10'h000;
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input int k, input logic [N-1:0] d);
        stb = 10'h001 << k;
        wr_data = d;
        @(posedge clk);
        #1;
    endtask

    task automatic t_regs();
        wr(0, 31'h6);
        wr(1, 31'h2);
        wr(1, 31'h0);
        check(mask_q, 32'h4);
        wr(1, 31'h4);
        check(mask_q, 32'h0);
        wr(3, 31'h30);
        wr(4, 31'h10);
        check(en_q, 32'h20);
        wr(4, 31'h20);
        for (int k = 0; k < 5; k++) begin
            wr(5 + k, 31'h1234_5678 >> k);
            check(cfg_q[k], 32'h1234_5678 >> k);
            wr(5 + k, 31'h0);
        end
    endtask

    task automatic t_rise();
        wr(6, 31'h8);
        wr(0, 31'h8);
        wr(3, 31'h8);
        pin[3] = 1'h1;
        go(3);
        check(pend_q, 32'h8);
        check(irq_req, 32'h0);
        go(1);
        check({irq_req[3], wake_request}, 32'h3);
        go(2);
        check(to_handler, 32'h1);
        wr(2, 31'h8);
        check(pend_q, 32'h0);
        pin[3] = 1'h0;
        wr(1, 31'h8);
        go(3);
        pin[3] = 1'h1;
        go(4);
        check({pend_q, irq_req[3], wake_request}, {31'h8, 2'h1});
        go(2);
        check({woke, to_handler}, 32'h2);
        wr(4, 31'h8);
        check({en_q, pend_q}, 64'h0);
        pin[3] = 1'h0;
        go(1);
        pin[3] = 1'h1;
        go(4);
        check(pend_q, 32'h0);
        pin[3] = 1'h0;
    endtask

    task automatic t_level();
        wr(5, 31'h20);
        wr(3, 31'hA0);
        go(3);
        check(pend_q, 32'h20);
        pin[7] = 1'h0;
        go(3);
        check(pend_q, 32'hA0);
        wr(2, 31'hA0);
        check(pend_q, 32'h20);
        wr(7, 31'h20);
        go(3);
        wr(2, 31'h20);
        check(pend_q, 32'h0);
        pin[5] = 1'h1;
        go(3);
        check(pend_q, 32'h20);
        pin[5] = 1'h0;
        wr(4, 31'hA0);
        wr(5, 31'h0);
        wr(7, 31'h0);
    endtask

    task automatic t_nmi();
        wr(6, 31'h1);
        wr(0, 31'h1);
        wr(3, 31'h1);
        pin[0] = 1'h1;
        go(4);
        check({nmi_req, irq_req}, {1'h1, 30'h0});
        wr(4, 31'h1);
        pin[0] = 1'h0;
    endtask

    task automatic t_filter();
        wr(6, 31'h200);
        wr(8, 31'h200);
        wr(3, 31'h200);
        pin[9] = 1'h1;
        go(1);
        pin[9] = 1'h0;
        go(6);
        check(pend_q, 32'h0);
        pin[9] = 1'h1;
        go(3);
        check(pend_q, 32'h0);
        go(3);
        check(pend_q, 32'h200);
        wr(4, 31'h200);
        wr(8, 31'h0);
        pin[9] = 1'h0;
    endtask

    task automatic t_async();
        wr(6, 31'h800);
        wr(8, 31'h800);
        wr(9, 31'h800);
        wr(3, 31'h800);
        go(2);
        pin[11] = 1'h1;
        go(3);
        check(wake_request, 32'h1);
        go(1);
        wr(2, 31'h800);
        check(pend_q, 32'h800);
        wr(4, 31'h800);
        pin[11] = 1'h0;
    endtask

    task automatic tally_and_finish();
        $display("checks=%0d miscompares=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        rst_n = 1'h0;
        pin = 31'h80;
        wr_data = 31'h0;
        go(10);
        rst_n = 1'h1;
        go(1);
        check({mask_q, en_q, pend_q}, 96'h0);
        t_regs();
        t_rise();
        t_level();
        t_nmi();
        t_filter();
        t_async();
        go(4);
        check(wake_request, 32'h0);
        tally_and_finish();
    end
endmodule // xic_ext_irq_ctrl_bench
`default_nettype wire

// [verilog/xic_ext_irq_ctrl.sv]
// External interrupt controller core: per-line control registers,
// pending state and request outputs toward the CPU side.
// Assumes clk is the detection clock and all strobes are synchronous.
`timescale 1ns/1ps
`default_nettype none
module xic_ext_irq_ctrl #(
    parameter int N = xic_pkg::NUM_LINES
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [N-1:0] ext_irq_pin,
    input  wire logic [N-1:0] wr_data,
    input  wire logic         mask_set_stb,
    input  wire logic         mask_clr_stb,
    input  wire logic         pend_clr_stb,
    input  wire logic         line_en_stb,
    input  wire logic         line_dis_stb,
    input  wire logic         mode_wr_stb,
    input  wire logic         edge_wr_stb,
    input  wire logic         level_wr_stb,
    input  wire logic         filter_wr_stb,
    input  wire logic         async_wr_stb,
    output var  logic [N-1:0] mask_state,
    output var  logic [N-1:0] pending_state,
    output var  logic [N-1:0] line_enabled,
    output var  logic [N-1:0] mode_state,
    output var  logic [N-1:0] edge_state,
    output var  logic [N-1:0] level_state,
    output var  logic [N-1:0] filter_state,
    output var  logic [N-1:0] async_state,
    output var  logic [N-1:1] irq_req,
    output var  logic         nmi_req,
    output var  logic         wake_request
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [N-1:0] gate(input logic         stb,
                                          input logic [N-1:0] data);
        return stb ? data : {N{xic_pkg::LINE_RST}};
    endfunction

    function automatic logic [N-1:0] set_clr(input logic [N-1:0] cur,
                                             input logic [N-1:0] set,
                                             input logic [N-1:0] clr);
        return (cur | set) & ~clr;
    endfunction

    function automatic logic [N-1:0] load(input logic [N-1:0] cur,
                                          input logic         stb,
                                          input logic [N-1:0] data);
        return stb ? data : cur;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [N-1:0] mask_reg;
    logic [N-1:0] pend_reg;
    logic [N-1:0] en_reg;
    logic [N-1:0] mode_reg;
    logic [N-1:0] edge_reg;
    logic [N-1:0] level_reg;
    logic [N-1:0] filt_reg;
    logic [N-1:0] async_reg;
    logic [N-1:1] irq_reg;
    logic         nmi_reg;
    logic         wake_reg;
    logic [N-1:0] pin_sync;

    xic_line_if #(.N(N)) lif ();

    // ------------------------------------------------------------
    // Decode of write strobes
    // ------------------------------------------------------------
    wire [N-1:0] mset_bits = gate(mask_set_stb, wr_data);
    wire [N-1:0] mclr_bits = gate(mask_clr_stb, wr_data);
    wire [N-1:0] pclr_bits = gate(pend_clr_stb, wr_data);
    wire [N-1:0] eset_bits = gate(line_en_stb,  wr_data);
    wire [N-1:0] eclr_bits = gate(line_dis_stb, wr_data);

    wire [N-1:0] mask_next = set_clr(mask_reg, mset_bits, mclr_bits);
    wire [N-1:0] en_next   = set_clr(en_reg, eset_bits, eclr_bits);
    wire [N-1:0] hit_bits  = lif.trig & en_reg;

    // New triggers win over a pending clear in the same cycle;
    // a disabled line is forced to zero.
    wire [N-1:0] pend_next = ((pend_reg & ~pclr_bits) | hit_bits)
                           & en_next;

    // An asynchronous hit raises wake together with its pending bit,
    // one cycle ahead of the wake that a synchronous line gives.
    wire         wake_next = (|pend_reg)
                           | (|(hit_bits & async_reg));

    // ------------------------------------------------------------
    // Detection path
    // ------------------------------------------------------------
    assign lif.mode_lvl   = mode_reg;
    assign lif.edge_rise  = edge_reg;
    assign lif.level_high = level_reg;
    assign lif.filt_on    = filt_reg;
    assign lif.async_on   = async_reg;

    // Runs on clk only; no halt input exists, so debug has no effect.
    xic_sync2 #(.N(N)) u_sync (
        .clk      (clk),
        .rst_n    (rst_n),
        .async_in (ext_irq_pin),
        .sync_out (pin_sync)
    );

    xic_line_det #(.N(N)) u_det (
        .clk     (clk),
        .rst_n   (rst_n),
        .sync_in (pin_sync),
        .cfg     (lif.det)
    );

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mode_reg  <= {N{xic_pkg::LINE_RST}};
            edge_reg  <= {N{xic_pkg::LINE_RST}};
            level_reg <= {N{xic_pkg::LINE_RST}};
            filt_reg  <= {N{xic_pkg::LINE_RST}};
            async_reg <= {N{xic_pkg::LINE_RST}};
        end else begin
            mode_reg  <= load(mode_reg,  mode_wr_stb,   wr_data);
            edge_reg  <= load(edge_reg,  edge_wr_stb,   wr_data);
            level_reg <= load(level_reg, level_wr_stb,  wr_data);
            filt_reg  <= load(filt_reg,  filter_wr_stb, wr_data);
            async_reg <= load(async_reg, async_wr_stb,  wr_data);
        end
    end

    // ------------------------------------------------------------
    // Mask, enable and pending state
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mask_reg <= {N{xic_pkg::LINE_RST}};
            en_reg   <= {N{xic_pkg::LINE_RST}};
            pend_reg <= {N{xic_pkg::LINE_RST}};
        end else begin
            mask_reg <= mask_next;
            en_reg   <= en_next;
            pend_reg <= pend_next;
        end
    end

    // ------------------------------------------------------------
    // Requests toward the CPU side
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_reg  <= {(N-1){xic_pkg::LINE_RST}};
            nmi_reg  <= xic_pkg::LINE_RST;
            wake_reg <= xic_pkg::LINE_RST;
        end else begin
            irq_reg  <= pend_reg[N-1:1] & mask_reg[N-1:1];
            nmi_reg  <= pend_reg[xic_pkg::NMI_BIT]
                      & mask_reg[xic_pkg::NMI_BIT];
            wake_reg <= wake_next;
        end
    end

    assign mask_state    = mask_reg;
    assign pending_state = pend_reg;
    assign line_enabled  = en_reg;
    assign mode_state    = mode_reg;
    assign edge_state    = edge_reg;
    assign level_state   = level_reg;
    assign filter_state  = filt_reg;
    assign async_state   = async_reg;
    assign irq_req       = irq_reg;
    assign nmi_req       = nmi_reg;
    assign wake_request  = wake_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    rst_dis_a: assert property (
        $rose(rst_n) |-> (line_enabled == '0 && mask_state == '0))
        else $error("lines not disabled after reset");

    mask_set_a: assert property (
        (mask_set_stb && !mask_clr_stb)
            |=> &(mask_state | ~$past(wr_data)))
        else $error("mask set write did not set mask");

    mask_clr_a: assert property (
        mask_clr_stb |=> ~|(mask_state & $past(wr_data)))
        else $error("mask clear write did not clear mask");

    mask_keep_a: assert property (
        (!mask_set_stb && !mask_clr_stb) |=> $stable(mask_state))
        else $error("mask state changed without a write");

    en_set_a: assert property (
        (line_en_stb && !line_dis_stb)
            |=> &(line_enabled | ~$past(wr_data)))
        else $error("enable write did not enable line");

    pend_en_a: assert property (
        ~|(pending_state & ~line_enabled))
        else $error("pending set on a disabled line");

    dis_clr_a: assert property (
        line_dis_stb |=> ~|(pending_state & $past(wr_data)))
        else $error("disable did not clear pending");

    pend_hold_a: assert property (
        ~|($past(pending_state) & ~pending_state
           & ~$past(pclr_bits) & line_enabled))
        else $error("pending dropped without a clear");

    trig_pend_a: assert property (
        !line_dis_stb |=> &(pending_state | ~$past(hit_bits)))
        else $error("trigger did not set pending");

    irq_route_a: assert property (
        ##1 irq_req == $past(pending_state[N-1:1] & mask_state[N-1:1]))
        else $error("request does not follow pending and mask");

    nmi_route_a: assert property (
        pending_state[xic_pkg::NMI_BIT] && mask_state[xic_pkg::NMI_BIT]
            |=> nmi_req)
        else $error("non-maskable request missing");

    wake_a: assert property (
        (|pending_state) |=> wake_request)
        else $error("wake missing while a line is pending");

    async_wake_a: assert property (
        (|(hit_bits & async_reg) && !line_dis_stb)
            |=> (wake_request && (|pending_state)))
        else $error("asynchronous wake not with pending");

    en_clr_a: assert property (
        line_dis_stb |=> ~|(line_enabled & $past(wr_data)))
        else $error("disable write did not disable line");

    en_keep_a: assert property (
        (!line_en_stb && !line_dis_stb) |=> $stable(line_enabled))
        else $error("enable state changed without a write");

    pend_clr_a: assert property (
        pend_clr_stb |=> ~|(pending_state & $past(pclr_bits) & ~$past(hit_bits)))
        else $error("pending clear write did not clear");

    pend_rise_a: assert property (
        ~|(pending_state & ~$past(pending_state) & ~$past(hit_bits)))
        else $error("pending set without a trigger");

    mode_load_a: assert property (
        mode_wr_stb |=> mode_state == $past(wr_data))
        else $error("mode write not loaded");

    edge_load_a: assert property (
        edge_wr_stb |=> edge_state == $past(wr_data))
        else $error("edge write not loaded");

    level_load_a: assert property (
        level_wr_stb |=> level_state == $past(wr_data))
        else $error("level write not loaded");

    filt_load_a: assert property (
        filter_wr_stb |=> filter_state == $past(wr_data))
        else $error("filter write not loaded");

    async_load_a: assert property (
        async_wr_stb |=> async_state == $past(wr_data))
        else $error("asynchronous write not loaded");

    irq_mask_a: assert property (
        ~|(irq_req & ~$past(mask_state[N-1:1])))
        else $error("request raised on a masked line");

    irq_fall_a: assert property (
        (~|pending_state[N-1:1]) |=> ~|irq_req)
        else $error("request stands without pending");

    nmi_block_a: assert property (
        !mask_state[xic_pkg::NMI_BIT] |=> !nmi_req)
        else $error("non-maskable request while masked");

    wake_drop_a: assert property (
        (~|pending_state && ~|(hit_bits & async_reg)) |=> !wake_request)
        else $error("wake raised with nothing pending");

    rst_out_a: assert property (
        $rose(rst_n) |-> (pending_state == '0 && ~|irq_req && !nmi_req && !wake_request))
        else $error("outputs not idle after reset");

    // ------------------------------------------------------------
    // Coverage
    // ------------------------------------------------------------
    nmi_seen_c: cover property ($rose(nmi_req));
    irq_seen_c: cover property ($rose(|irq_req));
    wake_only_c: cover property (wake_request && !nmi_req && ~|irq_req);
    async_c: cover property (|(hit_bits & async_reg));
    pend_masked_c: cover property (|(pending_state & ~mask_state));
endmodule // xic_ext_irq_ctrl
`default_nettype wire

// [verilog/xic_line_det.sv]
// Spike filter and edge or level detector for every line.
// Assumes synchronised inputs and static configuration from the core.
`timescale 1ns/1ps
`default_nettype none
module xic_line_det #(
    parameter int N = xic_pkg::NUM_LINES
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [N-1:0] sync_in,
    xic_line_if.det           cfg
);
    function automatic logic [N-1:0] maj3(input logic [N-1:0] a,
                                          input logic [N-1:0] b,
                                          input logic [N-1:0] c);
        return (a & b) | (a & c) | (b & c);
    endfunction

    logic [N-1:0] hist1_reg;
    logic [N-1:0] hist2_reg;
    logic [N-1:0] prev_reg;

    wire [N-1:0] use_filt = cfg.filt_on & ~cfg.async_on;
    wire [N-1:0] as_level = cfg.mode_lvl | cfg.async_on;
    wire [N-1:0] lvl_pol  = (cfg.async_on & cfg.edge_rise)
                          | (~cfg.async_on & cfg.level_high);
    wire [N-1:0] voted    = maj3(sync_in, hist1_reg, hist2_reg);
    wire [N-1:0] filt_val = (use_filt & voted) | (~use_filt & sync_in);
    wire [N-1:0] edge_hit = (cfg.edge_rise & filt_val & ~prev_reg)
                          | (~cfg.edge_rise & ~filt_val & prev_reg);
    wire [N-1:0] lvl_hit  = ~(filt_val ^ lvl_pol);

    assign cfg.trig = (as_level & lvl_hit) | (~as_level & edge_hit);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hist1_reg <= {N{xic_pkg::LINE_RST}};
            hist2_reg <= {N{xic_pkg::LINE_RST}};
            prev_reg  <= {N{xic_pkg::LINE_RST}};
        end else begin
            hist1_reg <= sync_in;
            hist2_reg <= hist1_reg;
            prev_reg  <= filt_val;
        end
    end

    filt_vote_a: assert property (@(posedge clk) disable iff (!rst_n)
        $past(rst_n) |-> ~|(use_filt & sync_in & $past(sync_in) & ~filt_val))
        else $error("filter ignored two of three high samples");
endmodule // xic_line_det
`default_nettype wire

// [verilog/xic_line_if.sv]
// Per-line trigger configuration and trigger results between the
// controller core and the line detector. Assumes one clock domain.
`timescale 1ns/1ps
`default_nettype none
interface xic_line_if #(
    parameter int N = xic_pkg::NUM_LINES
) ();
    logic [N-1:0] mode_lvl;
    logic [N-1:0] edge_rise;
    logic [N-1:0] level_high;
    logic [N-1:0] filt_on;
    logic [N-1:0] async_on;
    logic [N-1:0] trig;

    modport ctl (output mode_lvl, output edge_rise, output level_high,
                 output filt_on, output async_on, input trig);
    modport det (input mode_lvl, input edge_rise, input level_high,
                 input filt_on, input async_on, output trig);
endinterface
`default_nettype wire

// [verilog/xic_pkg.sv]
// Shared constants for the external interrupt controller.
// Assumes a SystemVerilog compiler; holds definitions only.
`default_nettype none
package xic_pkg;
    // Line count: the non-maskable line plus thirty ordinary lines
    localparam int         NUM_LINES   = 31;
    // Bit position of the non-maskable line in every per-line vector
    localparam int         NMI_BIT     = 0;
    // Pin synchroniser depth, in detection-clock cycles
    localparam int         SYNC_STAGES = 2;
    // Reset value of every per-line control and status bit
    localparam logic [0:0] LINE_RST    = 1'h0;
endpackage
`default_nettype wire

// [verilog/xic_sync2.sv]
// Two-stage pin synchroniser, one per line.
// Assumes pins are asynchronous to clk and may change at any time.
`timescale 1ns/1ps
`default_nettype none
module xic_sync2 #(
    parameter int N = xic_pkg::NUM_LINES
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [N-1:0] async_in,
    output var  logic [N-1:0] sync_out
);
    logic [N-1:0] meta_reg;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_reg <= {N{xic_pkg::LINE_RST}};
            sync_out <= {N{xic_pkg::LINE_RST}};
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

    sync_lat_a: assert property (@(posedge clk) disable iff (!rst_n)
        ($past(rst_n, 2) && $past(rst_n)) |-> sync_out == $past(async_in, 2))
        else $error("synchroniser latency is not two cycles");
endmodule // xic_sync2
`default_nettype wire
